// [inc/mem_err_pkg.sv]
// Shared encodings and reset values for the memory error recovery block
package mem_err_pkg;
  // Kind of error event reported by the channel logic
  typedef enum logic [2:0] {
    K_CORR = 3'h0,        // Correctable ECC data
    K_UNCORR = 3'h1,      // Uncorrectable or poisoned data, good CRC
    K_ALERT = 3'h2,       // Alert or corrupted write acknowledgement
    K_CRC = 3'h3,         // Northbound CRC error on read data
    K_SYNC = 3'h4,        // Northbound CRC error on sync status
    K_SPD = 3'h5,         // Serial presence interface protocol error
    K_SPARE_START = 3'h6, // Spare copy triggered
    K_SPARE_DONE = 3'h7   // Spare copy completed normally
  } kind_t;

  // Origin of the access that saw the error
  typedef enum logic [2:0] {
    S_DEMAND = 3'h0,   // Non-mirrored demand read
    S_MIRROR = 3'h1,   // Mirrored demand read
    S_SPARE = 3'h2,    // Sparing copy read from the failing rank
    S_PATROL = 3'h3,   // Patrol scrub read
    S_MEM_WR = 3'h4,   // Memory access packet
    S_CFG_WR = 3'h5,   // Module configuration write
    S_CFG_RD = 3'h6    // Configuration read
  } src_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,   // Accepting events
    ST_FRST = 2'b10    // Waiting for fast reset of both branches
  } state_t;

  // Log word layout: {kind, source, branch}
  localparam int LOG_W = 7;
  localparam int LOG_BRANCH_POS = 0;
  localparam int LOG_SRC_POS = 1;
  localparam int LOG_KIND_POS = 4;
  localparam logic [LOG_W-1:0] LOG_RST = 7'h00;
  localparam int RANK_W = 3;
  localparam int DEVCNT_W = 4;
endpackage

// [core/memory_error_recovery_policy.sv]
// Error classification, recovery sequencing and logging for the memory branches
//
// Behaviour
// - Mirrored first fail: reset both, replay other
// - After reset: disable failed branch unless both pass, replay or poison
// - Mirrored second fail: reset, disable, replay other
// - Spare copy uncorrectable: re-read, then poison or correct
// - Patrol uncorrectable: drop read, log recoverable
// - Memory alert: reset and replay, else degrade
// - Config write alert: reset and replay, else degrade
// - Read CRC: re-read other image, degrade, or replay
// - Correctable demand: return and write back corrected
// - Correctable spare copy: write spare destination
// - Correctable patrol: write back, log correctable
// - Sync CRC: drop, replay queued config command if the sync was for an alert
// - Log spare copy start and completion
// - Correctable ECC: logs, counter, device count, rank
// - Recoverable ECC: logs and uncorrectable counter
// - Interface protocol error: correctable, software retries
`timescale 1ns/1ns
module memory_error_recovery_policy
  import mem_err_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Error event from the channel logic
  input wire logic evt_valid,
  input wire kind_t evt_kind,
  input wire src_t evt_src,
  input wire logic evt_branch,
  input wire logic evt_redundant,
  input wire logic [RANK_W-1:0] evt_rank,
  input wire logic [DEVCNT_W-1:0] evt_devcnt,
  // Fast reset outcome and link status
  input wire logic frst_done,
  input wire logic [1:0] frst_pass,
  input wire logic frst_timeout,
  input wire logic sync_for_alert,
  input wire logic cfg_queued,
  // Software log clear
  input wire logic log_clear,
  // Recovery actions, one-cycle pulses except act_replay_branch_ff, which holds the replay branch
  output logic act_fast_reset_ff,
  output logic act_replay_ff,
  output logic act_replay_branch_ff,
  output logic act_reread_ff,
  output logic act_reread_other_ff,
  output logic act_poison_ff,
  output logic act_write_back_ff,
  output logic act_return_corrected_ff,
  output logic act_write_spare_ff,
  output logic act_auto_degrade_ff,
  output logic act_drop_ff,
  output logic act_replay_cfg_ff,
  output logic nonfatal_corr_ff,
  output logic nonfatal_rec_ff,
  // Status levels
  output logic busy_ff,
  output logic [1:0] branch_disabled_ff,
  // Logs and counters
  output logic first_log_valid_ff,
  output logic [LOG_W-1:0] first_nonfatal_memory_error_log_ff,
  output logic next_log_valid_ff,
  output logic [LOG_W-1:0] next_nonfatal_memory_error_log_ff,
  output logic [LOG_W-1:0] recoverable_memory_error_log_ff,
  output logic [LOG_W-1:0] recoverable_link_error_log_ff,
  output logic [LOG_W-1:0] config_write_error_log_ff,
  output logic [CNT_W-1:0] uncorrectable_error_counter_ff,
  output logic [CNT_W-1:0] correctable_error_counter_ff,
  output logic [DEVCNT_W-1:0] failing_device_counter_ff,
  output logic [RANK_W-1:0] failing_rank_record_ff
);

  // Saturating increment keeps a counter parked at all ones
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : CNT_W'(v + 1'b1);
  endfunction

  state_t state_ff;
  state_t nxt_state;
  logic pend_branch_ff;
  logic nxt_pend_branch;
  logic [1:0] nxt_disabled;
  logic nxt_frst, nxt_replay, nxt_rep_branch, nxt_reread, nxt_reread_other;
  logic nxt_poison, nxt_write_back, nxt_return, nxt_write_spare;
  logic nxt_degrade, nxt_drop, nxt_replay_cfg;
  logic accept;
  logic cls_corr, cls_rec;
  logic [LOG_W-1:0] evt_code;

  // Events are taken only while idle; the channel holds off while busy
  assign accept = evt_valid && state_ff == ST_IDLE;
  assign cls_corr = evt_kind inside {K_CORR, K_SYNC, K_SPD, K_SPARE_START, K_SPARE_DONE};
  assign cls_rec = evt_kind inside {K_UNCORR, K_ALERT, K_CRC};
  assign evt_code = {evt_kind, evt_src, evt_branch};

  // Recovery decision for the current event or fast reset outcome
  always_comb begin
    nxt_state = state_ff;
    nxt_pend_branch = pend_branch_ff;
    nxt_disabled = branch_disabled_ff;
    nxt_frst = 1'b0;
    nxt_replay = 1'b0;
    nxt_rep_branch = act_replay_branch_ff;
    nxt_reread = 1'b0;
    nxt_reread_other = 1'b0;
    nxt_poison = 1'b0;
    nxt_write_back = 1'b0;
    nxt_return = 1'b0;
    nxt_write_spare = 1'b0;
    nxt_degrade = 1'b0;
    nxt_drop = 1'b0;
    nxt_replay_cfg = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (frst_timeout) begin
          nxt_degrade = 1'b1;
        end
        if (accept) begin
          unique case (evt_kind)
            K_CORR: begin
              if (evt_src == S_SPARE) begin
                nxt_write_spare = 1'b1;
              end else if (evt_src == S_PATROL) begin
                nxt_write_back = 1'b1;
              end else begin
                nxt_write_back = 1'b1;
                nxt_return = 1'b1;
              end
            end
            K_UNCORR: begin
              if (evt_src == S_MIRROR && !evt_redundant) begin
                nxt_frst = 1'b1;
                nxt_pend_branch = evt_branch;
                nxt_state = ST_FRST;
              end else if (evt_src == S_MIRROR) begin
                nxt_frst = 1'b1;
                nxt_disabled[evt_branch] = 1'b1;
                nxt_replay = 1'b1;
                nxt_rep_branch = !evt_branch;
              end else if (evt_src == S_PATROL) begin
                nxt_drop = 1'b1;
              end else if (!evt_redundant) begin
                nxt_reread = 1'b1;
              end else begin
                nxt_poison = 1'b1;
              end
            end
            K_ALERT: begin
              // Memory packets and config writes share one policy
              if (evt_redundant) begin
                nxt_degrade = 1'b1;
              end else begin
                nxt_frst = 1'b1;
                nxt_replay = 1'b1;
                nxt_rep_branch = evt_branch;
              end
            end
            K_CRC: begin
              if (evt_src == S_MIRROR && !evt_redundant) begin
                nxt_reread_other = 1'b1;
                nxt_rep_branch = !evt_branch;
              end else if (evt_src == S_MIRROR) begin
                nxt_degrade = 1'b1;
              end else begin
                nxt_frst = 1'b1;
                nxt_replay = 1'b1;
                nxt_rep_branch = evt_branch;
              end
            end
            K_SYNC: begin
              nxt_drop = 1'b1;
              nxt_replay_cfg = sync_for_alert && cfg_queued;
            end
            // Protocol errors and spare copy markers are logged only
            K_SPD, K_SPARE_START, K_SPARE_DONE: begin
              nxt_drop = 1'b0;
            end
          endcase
        end
      end
      ST_FRST: begin
        if (frst_timeout) begin
          nxt_degrade = 1'b1;
          nxt_state = ST_IDLE;
        end else if (frst_done) begin
          nxt_state = ST_IDLE;
          if (frst_pass[pend_branch_ff] && frst_pass[!pend_branch_ff]) begin
            nxt_replay = 1'b1;
            nxt_rep_branch = !pend_branch_ff;
          end else if (frst_pass[!pend_branch_ff]) begin
            nxt_disabled[pend_branch_ff] = 1'b1;
            nxt_replay = 1'b1;
            nxt_rep_branch = !pend_branch_ff;
          end else begin
            nxt_disabled[pend_branch_ff] = 1'b1;
            nxt_poison = 1'b1;
          end
        end
      end
    endcase
  end

  // Sequencer state and sticky branch disables
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      pend_branch_ff <= 1'b0;
      branch_disabled_ff <= 2'h0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pend_branch_ff <= nxt_pend_branch;
      branch_disabled_ff <= nxt_disabled;
      busy_ff <= nxt_state == ST_FRST;
    end
  end

  // Action pulses, registered so every output leaves a flip-flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      act_fast_reset_ff <= 1'b0;
      act_replay_ff <= 1'b0;
      act_replay_branch_ff <= 1'b0;
      act_reread_ff <= 1'b0;
      act_reread_other_ff <= 1'b0;
      act_poison_ff <= 1'b0;
      act_write_back_ff <= 1'b0;
      act_return_corrected_ff <= 1'b0;
      act_write_spare_ff <= 1'b0;
      act_auto_degrade_ff <= 1'b0;
      act_drop_ff <= 1'b0;
      act_replay_cfg_ff <= 1'b0;
    end else begin
      act_fast_reset_ff <= nxt_frst;
      act_replay_ff <= nxt_replay;
      act_replay_branch_ff <= nxt_rep_branch;
      act_reread_ff <= nxt_reread;
      act_reread_other_ff <= nxt_reread_other;
      act_poison_ff <= nxt_poison;
      act_write_back_ff <= nxt_write_back;
      act_return_corrected_ff <= nxt_return;
      act_write_spare_ff <= nxt_write_spare;
      act_auto_degrade_ff <= nxt_degrade;
      act_drop_ff <= nxt_drop;
      act_replay_cfg_ff <= nxt_replay_cfg;
    end
  end

  // Class flags; protocol errors are correctable and never retried here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nonfatal_corr_ff <= 1'b0;
      nonfatal_rec_ff <= 1'b0;
    end else begin
      nonfatal_corr_ff <= accept && cls_corr;
      nonfatal_rec_ff <= accept && cls_rec;
    end
  end

  // First and next logs; a new error beats a clear in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      first_log_valid_ff <= 1'b0;
      next_log_valid_ff <= 1'b0;
      first_nonfatal_memory_error_log_ff <= LOG_RST;
      next_nonfatal_memory_error_log_ff <= LOG_RST;
    end else if (accept) begin
      if (!first_log_valid_ff || log_clear) begin
        first_log_valid_ff <= 1'b1;
        first_nonfatal_memory_error_log_ff <= evt_code;
        next_log_valid_ff <= 1'b0;
      end else begin
        next_log_valid_ff <= 1'b1;
        next_nonfatal_memory_error_log_ff <= evt_code;
      end
    end else if (log_clear) begin
      first_log_valid_ff <= 1'b0;
      next_log_valid_ff <= 1'b0;
    end
  end

  // Recoverable, link and config write logs hold the latest event
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      recoverable_memory_error_log_ff <= LOG_RST;
      recoverable_link_error_log_ff <= LOG_RST;
      config_write_error_log_ff <= LOG_RST;
    end else if (accept) begin
      if (evt_kind inside {K_CORR, K_UNCORR} || (evt_kind == K_ALERT && evt_src != S_CFG_WR)) begin
        recoverable_memory_error_log_ff <= evt_code;
      end
      if (evt_kind inside {K_CRC, K_SYNC}) begin
        recoverable_link_error_log_ff <= evt_code;
      end
      if (evt_kind == K_ALERT && evt_src == S_CFG_WR) begin
        config_write_error_log_ff <= evt_code;
      end
    end
  end

  // Counters saturate rather than wrap so a flood stays visible
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      uncorrectable_error_counter_ff <= '0;
      correctable_error_counter_ff <= '0;
      failing_device_counter_ff <= '0;
      failing_rank_record_ff <= '0;
    end else if (accept && evt_kind == K_UNCORR) begin
      uncorrectable_error_counter_ff <= sat_inc(uncorrectable_error_counter_ff);
    end else if (accept && evt_kind == K_CORR) begin
      correctable_error_counter_ff <= sat_inc(correctable_error_counter_ff);
      failing_device_counter_ff <= evt_devcnt;
      failing_rank_record_ff <= evt_rank;
    end
  end

  // Checks on the recovery policy
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_mirror_first_reset: assert property (
    accept && evt_kind == K_UNCORR && evt_src == S_MIRROR && !evt_redundant
    |=> act_fast_reset_ff && busy_ff && !act_replay_ff)
    else $error("mirrored first fail did not start fast reset");
  a_frst_both_pass: assert property (
    state_ff == ST_FRST && !frst_timeout && frst_done && (&frst_pass)
    |=> act_replay_ff && act_replay_branch_ff == !$past(pend_branch_ff) && !busy_ff)
    else $error("replay on other branch missing after good fast reset");
  a_frst_other_fail: assert property (
    state_ff == ST_FRST && !frst_timeout && frst_done && !frst_pass[!pend_branch_ff]
    |=> act_poison_ff && !act_replay_ff && branch_disabled_ff[$past(pend_branch_ff)])
    else $error("other branch fail did not poison and disable");
  a_mirror_second: assert property (
    accept && evt_kind == K_UNCORR && evt_src == S_MIRROR && evt_redundant
    |=> act_fast_reset_ff && act_replay_ff && branch_disabled_ff[$past(evt_branch)])
    else $error("second mirrored fail handling wrong");
  a_spare_reread: assert property (
    accept && evt_kind == K_UNCORR && evt_src == S_SPARE
    |=> (act_reread_ff != act_poison_ff) && act_poison_ff == $past(evt_redundant))
    else $error("spare copy re-read or poison wrong");
  a_patrol_drop: assert property (
    accept && evt_kind == K_UNCORR && evt_src == S_PATROL
    |=> act_drop_ff && !act_write_back_ff && nonfatal_rec_ff)
    else $error("patrol uncorrectable not dropped");
  a_alert_policy: assert property (
    accept && evt_kind == K_ALERT && !frst_timeout
    |=> act_auto_degrade_ff == $past(evt_redundant) && act_replay_ff == !$past(evt_redundant))
    else $error("alert recovery wrong");
  a_crc_policy: assert property (
    accept && evt_kind == K_CRC && evt_src != S_MIRROR
    |=> act_fast_reset_ff && act_replay_ff && act_replay_branch_ff == $past(evt_branch))
    else $error("crc replay not on same branch");
  a_demand_correct: assert property (
    accept && evt_kind == K_CORR && evt_src inside {S_DEMAND, S_MIRROR}
    |=> act_write_back_ff && act_return_corrected_ff && !act_write_spare_ff)
    else $error("corrected demand data not returned and written");
  a_corr_count: assert property (
    accept && evt_kind == K_CORR && !(&correctable_error_counter_ff)
    |=> correctable_error_counter_ff == CNT_W'($past(correctable_error_counter_ff) + 1'b1)
        && failing_rank_record_ff == $past(evt_rank))
    else $error("correctable counter or rank not updated");
  a_first_hold: assert property (
    first_log_valid_ff && !log_clear |=> first_log_valid_ff
        && $stable(first_nonfatal_memory_error_log_ff))
    else $error("first error log overwritten");

  c_mirror_recover: cover property (accept && evt_kind == K_UNCORR && evt_src == S_MIRROR
    && !evt_redundant ##[1:20] act_replay_ff);
  c_degrade: cover property (act_auto_degrade_ff);
  c_next_log: cover property (first_log_valid_ff ##1 next_log_valid_ff);
  c_sync_replay: cover property (act_replay_cfg_ff);

endmodule // memory_error_recovery_policy

// [dv/mem_branch_model.sv]
// Behavioural model of the two memory branches answering fast reset requests
`timescale 1ns/1ns
module mem_branch_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request from the recovery block
  input wire logic fast_reset,
  // Outcome and pace chosen by the bench
  input wire logic [1:0] pass_cfg,
  input wire logic [2:0] delay_cfg,
  input wire logic hang_cfg,
  // Outcome back to the recovery block
  output logic frst_done,
  output logic [1:0] frst_pass,
  output logic frst_timeout
);
  logic [2:0] wait_ff;

  // Both branches retrain together and report after the commanded delay; a hang times out
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 3'h0;
      frst_done <= 1'b0;
      frst_pass <= 2'h0;
      frst_timeout <= 1'b0;
    end else begin
      frst_done <= wait_ff == 3'h1 && !hang_cfg;
      frst_timeout <= wait_ff == 3'h1 && hang_cfg;
      // Pass bits mean nothing outside the done pulse, so they churn to expose misuse
      frst_pass <= (wait_ff == 3'h1) ? pass_cfg : ~frst_pass;
      if (fast_reset) begin
        wait_ff <= delay_cfg;
      end else if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule // mem_branch_model

// [dv/test_memory_error_recovery_policy.sv]
// Self-checking bench for the memory error recovery policy block
`timescale 1ns/1ns
module test_memory_error_recovery_policy;
  import mem_err_pkg::*;
  // Bits of the action vector used by the action comparisons
  localparam logic [12:0] FR = 13'h1000, RP = 13'h0800, RR = 13'h0400, RO = 13'h0200;
  localparam logic [12:0] PO = 13'h0100, WB = 13'h0080, RC = 13'h0040, WS = 13'h0020;
  localparam logic [12:0] AD = 13'h0010, DR = 13'h0008, RQ = 13'h0004, NC = 13'h0002;
  localparam logic [12:0] NR = 13'h0001;
  // Stimulus
  logic clock = 1'b0;
  logic rstn;
  logic evt_valid = 1'b0, evt_branch = 1'b0, evt_redundant = 1'b0, log_clear = 1'b0;
  logic sync_for_alert = 1'b0, cfg_queued = 1'b0, hang_cfg = 1'b0;
  kind_t evt_kind = K_CORR;
  src_t evt_src = S_DEMAND;
  logic [RANK_W-1:0] evt_rank = 3'h0;
  logic [DEVCNT_W-1:0] evt_devcnt = 4'h0;
  logic [1:0] pass_cfg = 2'h3;
  logic [2:0] delay_cfg = 3'h1;
  // Partner answers and observed outputs
  logic frst_done, frst_timeout;
  logic [1:0] frst_pass;
  logic act_fast_reset_ff, act_replay_ff, act_replay_branch_ff, act_reread_ff;
  logic act_reread_other_ff, act_poison_ff, act_write_back_ff, act_return_corrected_ff;
  logic act_write_spare_ff, act_auto_degrade_ff, act_drop_ff, act_replay_cfg_ff;
  logic nonfatal_corr_ff, nonfatal_rec_ff, busy_ff, first_log_valid_ff, next_log_valid_ff;
  logic [1:0] branch_disabled_ff;
  logic [LOG_W-1:0] first_nonfatal_memory_error_log_ff, next_nonfatal_memory_error_log_ff;
  logic [LOG_W-1:0] recoverable_memory_error_log_ff, recoverable_link_error_log_ff;
  logic [LOG_W-1:0] config_write_error_log_ff;
  logic [15:0] uncorrectable_error_counter_ff, correctable_error_counter_ff;
  logic [DEVCNT_W-1:0] failing_device_counter_ff;
  logic [RANK_W-1:0] failing_rank_record_ff;
  int failures = 0;
  int n_checks = 0;
  // All pulses packed so that a stray extra action also fails a comparison
  wire [12:0] acts = {act_fast_reset_ff, act_replay_ff, act_reread_ff, act_reread_other_ff,
    act_poison_ff, act_write_back_ff, act_return_corrected_ff, act_write_spare_ff,
    act_auto_degrade_ff, act_drop_ff, act_replay_cfg_ff, nonfatal_corr_ff, nonfatal_rec_ff};

  // Design and far-side model
  memory_error_recovery_policy #(.CNT_W(16)) i_dut (.*);
  mem_branch_model i_mem (.clock(clock), .rstn(rstn), .fast_reset(act_fast_reset_ff),
    .pass_cfg(pass_cfg), .delay_cfg(delay_cfg), .hang_cfg(hang_cfg), .frst_done(frst_done),
    .frst_pass(frst_pass), .frst_timeout(frst_timeout));

  // 25 MHz clock
  always #20 clock = ~clock;

  task automatic test_done();
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [LOG_W-1:0] lw(input kind_t k, input src_t s, input logic b);
    return {k, s, b};
  endfunction

  // Reset leaves every output at zero on the first edge after release
  task automatic do_reset();
    rstn = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    rstn = 1'b1;
    @(posedge clock);
    #1;
    check({acts, busy_ff, branch_disabled_ff, first_log_valid_ff, next_log_valid_ff}, 0);
  endtask

  // One event pulse; returns when the answer cycle is visible
  task automatic send(input kind_t k, input src_t s, input logic b, input logic r);
    @(posedge clock);
    #1;
    evt_kind = k;
    evt_src = s;
    evt_branch = b;
    evt_redundant = r;
    evt_valid = 1'b1;
    @(posedge clock);
    #1;
    evt_valid = 1'b0;
  endtask

  // Bounded wait for the cycle that carries the fast reset outcome
  task automatic wait_outcome();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (acts === 13'h0000 && i < 40);
    // An outcome on the last try is still an outcome
    if (acts === 13'h0000) begin
      failures++;
      $display("ERROR %0t: no fast reset outcome", $time);
      test_done();
    end
  endtask

  task automatic s_correctable();
    evt_rank = 3'h5;
    evt_devcnt = 4'h3;
    send(K_CORR, S_DEMAND, 1'b0, 1'b0);
    check(acts, WB | RC | NC);
    check({correctable_error_counter_ff, failing_rank_record_ff, failing_device_counter_ff},
      {16'h0001, 3'h5, 4'h3});
    check({first_log_valid_ff, next_log_valid_ff, first_nonfatal_memory_error_log_ff,
      recoverable_memory_error_log_ff}, {2'b10, lw(K_CORR, S_DEMAND, 1'b0),
      lw(K_CORR, S_DEMAND, 1'b0)});
    send(K_CORR, S_MIRROR, 1'b1, 1'b0);
    check(acts, WB | RC | NC);
    check({first_log_valid_ff, next_log_valid_ff, first_nonfatal_memory_error_log_ff,
      next_nonfatal_memory_error_log_ff}, {2'b11, lw(K_CORR, S_DEMAND, 1'b0),
      lw(K_CORR, S_MIRROR, 1'b1)});
    send(K_CORR, S_SPARE, 1'b0, 1'b0);
    check(acts, WS | NC);
    send(K_CORR, S_PATROL, 1'b1, 1'b0);
    check(acts, WB | NC);
    check(correctable_error_counter_ff, 16'h0004);
  endtask

  task automatic s_spare_patrol();
    send(K_UNCORR, S_SPARE, 1'b0, 1'b0);
    check(acts, RR | NR);
    send(K_UNCORR, S_SPARE, 1'b0, 1'b1);
    check(acts, PO | NR);
    send(K_CORR, S_SPARE, 1'b0, 1'b1);
    check(acts, WS | NC);
    send(K_UNCORR, S_PATROL, 1'b1, 1'b0);
    check(acts, DR | NR);
    check({recoverable_memory_error_log_ff, uncorrectable_error_counter_ff},
      {lw(K_UNCORR, S_PATROL, 1'b1), 16'h0003});
  endtask

  // Mirrored failures with prompt and slow fast reset answers
  task automatic s_mirror();
    send(K_UNCORR, S_MIRROR, 1'b0, 1'b0);
    check({acts, busy_ff}, {FR | NR, 1'b1});
    wait_outcome();
    check({acts, act_replay_branch_ff, busy_ff, branch_disabled_ff}, {RP, 4'b1000});
    pass_cfg = 2'b10;
    delay_cfg = 3'h5;
    send(K_UNCORR, S_MIRROR, 1'b0, 1'b0);
    wait_outcome();
    check({acts, act_replay_branch_ff, branch_disabled_ff}, {RP, 3'b101});
    pass_cfg = 2'b11;
    // A second failure resets, disables and replays in one cycle; no outcome is awaited
    send(K_UNCORR, S_MIRROR, 1'b1, 1'b1);
    check(acts, FR | RP | NR);
    check({act_replay_branch_ff, branch_disabled_ff}, 3'b011);
    do_reset();
    pass_cfg = 2'b01;
    send(K_UNCORR, S_MIRROR, 1'b0, 1'b0);
    wait_outcome();
    check({acts, branch_disabled_ff}, {PO, 2'b01});
  endtask

  task automatic s_alert();
    src_t s;
    pass_cfg = 2'b11;
    delay_cfg = 3'h1;
    for (int j = 0; j < 2; j++) begin
      s = (j == 0) ? S_MEM_WR : S_CFG_WR;
      // Fast reset and replay leave together; the later done pulse lands while idle
      send(K_ALERT, s, 1'b1, 1'b0);
      check(acts, FR | RP | NR);
      check(act_replay_branch_ff, 1'b1);
      send(K_ALERT, s, 1'b1, 1'b1);
      check(acts, AD | NR);
    end
    check(config_write_error_log_ff, lw(K_ALERT, S_CFG_WR, 1'b1));
    hang_cfg = 1'b1;
    send(K_ALERT, S_MEM_WR, 1'b1, 1'b0);
    wait_outcome();
    check({acts, busy_ff}, {AD, 1'b0});
    hang_cfg = 1'b0;
  endtask

  task automatic s_crc();
    send(K_CRC, S_MIRROR, 1'b0, 1'b0);
    check({acts, act_replay_branch_ff}, {RO | NR, 1'b1});
    send(K_CRC, S_MIRROR, 1'b1, 1'b1);
    check({acts, recoverable_link_error_log_ff}, {AD | NR, lw(K_CRC, S_MIRROR, 1'b1)});
    send(K_CRC, S_CFG_RD, 1'b1, 1'b0);
    check(acts, FR | RP | NR);
    check(act_replay_branch_ff, 1'b1);
  endtask

  // Sync status errors, presence interface errors and spare copy progress
  task automatic s_misc();
    sync_for_alert = 1'b1;
    cfg_queued = 1'b1;
    send(K_SYNC, S_CFG_WR, 1'b0, 1'b0);
    check(acts, DR | RQ | NC);
    sync_for_alert = 1'b0;
    send(K_SYNC, S_CFG_WR, 1'b0, 1'b0);
    check(acts, DR | NC);
    send(K_SPD, S_CFG_RD, 1'b0, 1'b0);
    check(acts, NC);
    send(K_SPARE_START, S_SPARE, 1'b0, 1'b0);
    check(acts, NC);
    send(K_SPARE_DONE, S_SPARE, 1'b1, 1'b0);
    check({acts, next_nonfatal_memory_error_log_ff},
      {NC, lw(K_SPARE_DONE, S_SPARE, 1'b1)});
    @(posedge clock);
    #1;
    log_clear = 1'b1;
    @(posedge clock);
    #1;
    log_clear = 1'b0;
    check({first_log_valid_ff, next_log_valid_ff}, 2'b00);
    send(K_SPD, S_CFG_RD, 1'b1, 1'b0);
    check({first_log_valid_ff, next_log_valid_ff, first_nonfatal_memory_error_log_ff},
      {2'b10, lw(K_SPD, S_CFG_RD, 1'b1)});
  endtask

  // Main sequence
  initial begin
    do_reset();
    s_correctable();
    s_spare_patrol();
    s_mirror();
    s_alert();
    s_crc();
    s_misc();
    test_done();
  end
endmodule // test_memory_error_recovery_policy
